// ---- verilog/lcd_cmd_defs.svh ----
/*
 * Constants of the host command decoder: command codes, parameter counts,
 * reset values and frame timing.
 * Assumes it is included by the package and by the top module only.
 */
// How it works
// [RULE1] Two select inputs choose 8080 or 6800 style host bus; host ties them
// [RULE2] 8080: separate read/write strobes; 6800: enable clock plus read/not-write level
// [RULE3] Command write has select high; 40h init takes 8 bytes, 53h standby none
// [RULE4] 58h/59h turn display off/on by bit 0, then one attribute byte
// [RULE5] 44h takes 10 start/region bytes; 5Ah takes one pixel pan byte
// [RULE6] 5Dh takes two cursor shape bytes; 5Bh one layer mix byte
// [RULE7] 5Ch takes two bytes of character RAM base address
// [RULE8] 4Ch-4Fh set cursor step direction from low two bits, no bytes
// [RULE9] 46h writes, 47h reads cursor address one byte at a time
// [RULE10] After 42h every data byte goes to display memory at the cursor; code drops a byte that arrives while the write buffer is full
// [RULE11] After 43h host data reads return display memory bytes at the cursor
// [RULE12] Each parameter register updates as soon as its byte arrives
// [RULE13] A new command may cut a list short; unsent registers stay unchanged
// [RULE14] Paired bytes of init, scroll, char RAM base commit together; code pairs only scroll and char RAM base
// [RULE15] Pitch low and high bytes commit on their own
// [RULE16] A power-down output flags that display drive is blanked
// [RULE17] Power-down output high while driving, low one or two frames after standby
// [RULE18] Init restarts timing, disables display, cancels standby
// [RULE19] Data bytes go to the latest command, index restarting at zero
`ifndef LCD_CMD_DEFS_SVH
`define LCD_CMD_DEFS_SVH

`define CMD_INIT 8'h40
`define CMD_SLEEP 8'h53
`define CMD_DISP_HI 7'h2c
`define CMD_SCROLL 8'h44
`define CMD_SHAPE 8'h5d
`define CMD_CGRAM 8'h5c
`define CMD_DIR_HI 6'h13
`define CMD_PAN 8'h5a
`define CMD_LAYER 8'h5b
`define CMD_CURW 8'h46
`define CMD_CURR 8'h47
`define CMD_MEMWR 8'h42
`define CMD_MEMRD 8'h43

`define INIT_COUNT 4'h8
`define SCROLL_COUNT 4'ha
`define SHAPE_COUNT 4'h2
`define IDX_MAX 4'hf
`define PITCH_LO_IDX 3'h6
`define PITCH_HI_IDX 3'h7

`define CMD_RESET 8'h00
`define CURSOR_RESET 16'h0000
`define RD_DATA_RESET 8'h00

`define CLOCK_MHZ 20
`define FRAME_TIME_US 14286
`define FRAME_CYCLES (`FRAME_TIME_US * `CLOCK_MHZ)
`define FIFO_DEPTH 16

`endif

// ---- verilog/lcd_cmd_pkg.sv ----
/*
 * Types of the host command decoder and the command code decoder.
 * Assumes the defs header is on the include path.
 */
`include "lcd_cmd_defs.svh"
package lcd_cmd_pkg;
    typedef enum logic [3:0] {K_NONE, K_INIT, K_SLEEP, K_DISP, K_SCROLL, K_SHAPE, K_CGRAM,
        K_DIR, K_PAN, K_LAYER, K_CURW, K_CURR, K_MWR, K_MRD} cmd_kind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} read_state_t;
    typedef struct packed {
        logic wr;
        logic rd_end;
        logic is_cmd;
        logic [7:0] data;
    } host_op_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } vram_wr_t;
    typedef struct packed {
        logic [7:0][7:0] init;
        logic [9:0][7:0] scroll;
        logic [1:0][7:0] shape;
        logic [15:0] char_base;
        logic [7:0] overlay;
        logic [7:0] pan;
        logic [7:0] disp_attr;
        logic [1:0] cursor_dir;
        logic display_on;
        logic standby;
    } params_t;

    // Command code to command kind
    function automatic cmd_kind_t decode_kind(input logic [7:0] c);
        cmd_kind_t k;
        k = K_NONE;
        if (c == `CMD_INIT) k = K_INIT;
        if (c == `CMD_SLEEP) k = K_SLEEP;
        if (c[7:1] == `CMD_DISP_HI) k = K_DISP;
        if (c == `CMD_SCROLL) k = K_SCROLL;
        if (c == `CMD_SHAPE) k = K_SHAPE;
        if (c == `CMD_CGRAM) k = K_CGRAM;
        if (c[7:2] == `CMD_DIR_HI) k = K_DIR;
        if (c == `CMD_PAN) k = K_PAN;
        if (c == `CMD_LAYER) k = K_LAYER;
        if (c == `CMD_CURW) k = K_CURW;
        if (c == `CMD_CURR) k = K_CURR;
        if (c == `CMD_MEMWR) k = K_MWR;
        if (c == `CMD_MEMRD) k = K_MRD;
        return k;
    endfunction
endpackage

// ---- verilog/byte_fifo.sv ----
/*
 * Flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Honest flags straight from the fill count
    assign in_ready = count_reg != (AW+1)'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data = mem_reg[rd_ptr_reg];

    // Storage written only on push
    always_ff @(posedge clk) begin
        if (push) mem_reg[wr_ptr_reg] <= in_data;
    end

    // Pointers wrap at the depth, which must be a power of two
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- verilog/host_bus_front.sv ----
/*
 * Host bus front end: turns 8080 or 6800 style strobes into one-cycle
 * write and read-end events with the byte and the select bit.
 * Assumes all host pins are synchronous to the clock.
 */
`timescale 1ns/1ps
module host_bus_front import lcd_cmd_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic style_a,
    input wire logic style_b,
    input wire logic chip_select_n,
    input wire logic cd_sel,
    input wire logic strobe_rd_e,
    input wire logic strobe_wr_rw,
    input wire logic [7:0] data_in,
    output host_op_t op,
    output logic drive_en
);
    logic wr_prev_reg;
    logic rd_prev_reg;
    host_op_t op_reg;

    // Bus style from the two select levels
    wire style_6800 = style_a & ~style_b; // [RULE1]
    wire selected = ~chip_select_n;
    // Strobe meaning per style
    wire wr_act = style_6800 ? (strobe_rd_e & ~strobe_wr_rw) : ~strobe_wr_rw; // [RULE2]
    wire rd_act = style_6800 ? (strobe_rd_e & strobe_wr_rw) : ~strobe_rd_e; // [RULE2]

    // Bus turned only while a selected read stands
    assign drive_en = rd_act & selected;
    assign op = op_reg;

    // Writes taken at strobe start; a read ends when its strobe drops
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_prev_reg <= 1'b0;
            rd_prev_reg <= 1'b0;
            op_reg <= '0;
        end else begin
            wr_prev_reg <= wr_act & selected;
            rd_prev_reg <= rd_act & selected;
            op_reg.wr <= wr_act & selected & ~wr_prev_reg;
            op_reg.rd_end <= rd_prev_reg & ~(rd_act & selected);
            op_reg.is_cmd <= cd_sel; // [RULE3]
            op_reg.data <= data_in;
        end
    end
endmodule

// ---- verilog/lcd_host_command_decoder.sv ----
/*
 * Host command decoder: takes command and parameter bytes from the host
 * bus, keeps the parameter registers, runs the display memory write and
 * read streams and the cursor, and drives the power-down output.
 * Assumes a memory port that takes one read request per cycle and answers
 * with a valid pulse, and a host that watches BUSY before memory traffic.
 */
`timescale 1ns/1ps
`include "lcd_cmd_defs.svh"
module lcd_host_command_decoder import lcd_cmd_pkg::*; #(
    parameter int unsigned FRAME_CYCLES = `FRAME_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic BUS_STYLE_SELECT_A,
    input wire logic BUS_STYLE_SELECT_B,
    input wire logic CHIP_SELECT_N,
    input wire logic COMMAND_DATA_SELECT,
    input wire logic STROBE_RD_E,
    input wire logic STROBE_WR_RW,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic BUSY,
    output vram_wr_t VRAM_WR,
    output logic VRAM_WR_VALID,
    input wire logic VRAM_WR_READY,
    output logic VRAM_RD_REQ,
    output logic [15:0] VRAM_RD_ADDR,
    input wire logic VRAM_RD_VALID,
    input wire logic [7:0] VRAM_RD_DATA,
    output params_t PARAMS,
    output logic [15:0] CURSOR_ADDR,
    output logic TIMING_RESTART,
    output logic DRIVE_BLANK_OUT
);
    host_op_t op;
    logic [7:0] cmd_reg;
    logic [3:0] idx_reg;
    params_t params_reg;
    logic [7:0] pend_reg;
    logic [15:0] cursor_reg;
    logic [15:0] cursor_next;
    logic [7:0] rd_data_reg;
    read_state_t rd_state_reg;
    read_state_t rd_state_next;
    logic [31:0] frame_cnt_reg;
    logic blank_cnt_reg;
    logic drive_reg;
    logic restart_reg;
    logic fifo_in_ready;

    // Step the cursor one place in the chosen direction
    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] dir,
                                         input logic [15:0] pitch);
        logic [15:0] r;
        r = a;
        case (dir)
            2'h0: r = a + 16'h0001;
            2'h1: r = a - 16'h0001;
            2'h2: r = a - pitch;
            2'h3: r = a + pitch;
            default: r = a;
        endcase
        return r;
    endfunction

    // First byte of a pair that commits only with its partner
    function automatic logic pair_low(input cmd_kind_t k, input logic [3:0] i);
        return (k == K_CGRAM && i == 4'h0) ||
               (k == K_SCROLL && (i == 4'h0 || i == 4'h3 || i == 4'h6 || i == 4'h8));
    endfunction

    function automatic logic pair_high(input cmd_kind_t k, input logic [3:0] i);
        return (k == K_CGRAM && i == 4'h1) ||
               (k == K_SCROLL && (i == 4'h1 || i == 4'h4 || i == 4'h7 || i == 4'h9));
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Host bus front end and memory write buffer

    host_bus_front front (
        .clk(CLOCK),
        .rst(RESET),
        .style_a(BUS_STYLE_SELECT_A),
        .style_b(BUS_STYLE_SELECT_B),
        .chip_select_n(CHIP_SELECT_N),
        .cd_sel(COMMAND_DATA_SELECT),
        .strobe_rd_e(STROBE_RD_E),
        .strobe_wr_rw(STROBE_WR_RW),
        .data_in(DATA_IN),
        .op(op),
        .drive_en(DATA_OE)
    );

    // Command and data split, kinds of the held and the arriving code
    wire new_cmd = op.wr & op.is_cmd;
    wire param_wr = op.wr & ~op.is_cmd; // [RULE19]
    wire data_rd = op.rd_end & ~op.is_cmd;
    wire cmd_kind_t kind = decode_kind(cmd_reg);
    wire cmd_kind_t new_kind = decode_kind(op.data);
    wire [15:0] pitch = {params_reg.init[`PITCH_HI_IDX], params_reg.init[`PITCH_LO_IDX]};

    // A byte is dropped when the buffer is full; BUSY warns the host first
    wire mwr_push = param_wr & (kind == K_MWR); // [RULE10]
    wire mwr_taken = mwr_push & fifo_in_ready;

    byte_fifo #(.WIDTH(24), .DEPTH(`FIFO_DEPTH)) wr_buf (
        .clk(CLOCK),
        .rst(RESET),
        .in_valid(mwr_push),
        .in_ready(fifo_in_ready),
        .in_data({cursor_reg, op.data}),
        .out_valid(VRAM_WR_VALID),
        .out_ready(VRAM_WR_READY),
        .out_data(VRAM_WR)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command code and parameter index

    // Index restarts on every code and saturates past the list
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cmd_reg <= `CMD_RESET;
            idx_reg <= 4'h0;
        end else if (new_cmd) begin
            cmd_reg <= op.data; // [RULE3]
            idx_reg <= 4'h0; // [RULE19]
        end else if ((param_wr || (data_rd && kind == K_CURR)) && idx_reg != `IDX_MAX) begin
            idx_reg <= idx_reg + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parameter registers, each written the moment its byte lands; a pair's low half waits for the high

    // Low half of a pair waits here and is lost if the command changes
    always_ff @(posedge CLOCK) begin
        if (RESET) pend_reg <= 8'h00;
        else if (param_wr && pair_low(kind, idx_reg)) pend_reg <= op.data; // [RULE14]
    end

    // Flags set by the command code itself
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            params_reg.display_on <= 1'b0;
            params_reg.standby <= 1'b0;
            params_reg.cursor_dir <= 2'h0;
        end else if (new_cmd) begin
            case (new_kind)
                K_DISP: params_reg.display_on <= op.data[0]; // [RULE4]
                K_DIR: params_reg.cursor_dir <= op.data[1:0]; // [RULE8]
                K_SLEEP: params_reg.standby <= 1'b1; // [RULE3]
                K_INIT: begin
                    params_reg.display_on <= 1'b0; // [RULE18]
                    params_reg.standby <= 1'b0; // [RULE18]
                end
                default: ;
            endcase
        end
    end

    // Byte parameters; unsent ones keep their old value
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            params_reg.init <= '0;
            params_reg.scroll <= '0;
            params_reg.shape <= '0;
            params_reg.char_base <= '0;
            params_reg.overlay <= 8'h00;
            params_reg.pan <= 8'h00;
            params_reg.disp_attr <= 8'h00;
        end else if (param_wr) begin // [RULE12] [RULE13]
            case (kind)
                K_INIT: begin
                    // Pitch bytes land one by one like every other init byte
                    if (idx_reg < `INIT_COUNT) params_reg.init[idx_reg[2:0]] <= op.data; // [RULE15]
                end
                K_DISP: if (idx_reg == 4'h0) params_reg.disp_attr <= op.data; // [RULE4]
                K_SCROLL: begin
                    if (pair_high(kind, idx_reg)) begin
                        params_reg.scroll[4'(idx_reg - 4'h1)] <= pend_reg; // [RULE14]
                        params_reg.scroll[idx_reg] <= op.data; // [RULE5]
                    end else if (!pair_low(kind, idx_reg) && idx_reg < `SCROLL_COUNT) begin
                        params_reg.scroll[idx_reg] <= op.data; // [RULE5]
                    end
                end
                K_SHAPE: begin
                    if (idx_reg < `SHAPE_COUNT) params_reg.shape[idx_reg[0]] <= op.data; // [RULE6]
                end
                K_CGRAM: begin
                    if (pair_high(kind, idx_reg)) params_reg.char_base <= {op.data, pend_reg}; // [RULE7]
                end
                K_PAN: if (idx_reg == 4'h0) params_reg.pan <= op.data; // [RULE5]
                K_LAYER: if (idx_reg == 4'h0) params_reg.overlay <= op.data; // [RULE6]
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cursor and display memory streams

    // Cursor write per byte, stream steps after each memory byte
    always_comb begin
        cursor_next = cursor_reg;
        if (param_wr && kind == K_CURW && idx_reg == 4'h0) begin
            cursor_next = {cursor_reg[15:8], op.data}; // [RULE9]
        end else if (param_wr && kind == K_CURW && idx_reg == 4'h1) begin
            cursor_next = {op.data, cursor_reg[7:0]}; // [RULE9]
        end else if (mwr_taken || (rd_state_reg == ST_WAIT && VRAM_RD_VALID)) begin
            cursor_next = step(cursor_reg, params_reg.cursor_dir, pitch); // [RULE10] [RULE11]
        end
    end

    // Memory read stream: one fetch ahead, refilled after each host read
    always_comb begin
        rd_state_next = rd_state_reg;
        case (rd_state_reg)
            ST_IDLE: begin
                if ((new_cmd && new_kind == K_MRD) || (data_rd && kind == K_MRD)) begin
                    rd_state_next = ST_REQ; // [RULE11]
                end
            end
            ST_REQ: rd_state_next = new_cmd ? ST_IDLE : ST_WAIT;
            ST_WAIT: begin
                if (new_cmd || VRAM_RD_VALID) rd_state_next = ST_IDLE;
            end
            default: rd_state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cursor_reg <= `CURSOR_RESET;
            rd_state_reg <= ST_IDLE;
        end else begin
            cursor_reg <= cursor_next;
            rd_state_reg <= rd_state_next;
        end
    end

    // Read byte: cursor halves for cursor reads, fetched memory otherwise
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rd_data_reg <= `RD_DATA_RESET;
        end else if (new_cmd && new_kind == K_CURR) begin
            rd_data_reg <= cursor_reg[7:0]; // [RULE9]
        end else if (data_rd && kind == K_CURR && idx_reg == 4'h0) begin
            rd_data_reg <= cursor_reg[15:8]; // [RULE9]
        end else if (rd_state_reg == ST_WAIT && VRAM_RD_VALID) begin
            rd_data_reg <= VRAM_RD_DATA; // [RULE11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame timing and power-down output

    // Frame divider, restarted by the init command
    wire frame_tick = frame_cnt_reg == FRAME_CYCLES - 1;
    wire init_cmd = new_cmd && new_kind == K_INIT;

    always_ff @(posedge CLOCK) begin
        if (RESET || init_cmd || frame_tick) frame_cnt_reg <= 32'h0; // [RULE18]
        else frame_cnt_reg <= frame_cnt_reg + 32'h1;
    end

    // Drive stops at the second frame edge in standby: one or two frames
    always_ff @(posedge CLOCK) begin
        if (RESET || !params_reg.standby) begin
            blank_cnt_reg <= 1'b0;
            drive_reg <= 1'b1; // [RULE17]
        end else if (frame_tick) begin
            blank_cnt_reg <= 1'b1;
            if (blank_cnt_reg) drive_reg <= 1'b0; // [RULE16] [RULE17]
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) restart_reg <= 1'b0;
        else restart_reg <= init_cmd; // [RULE18]
    end

    // Outputs
    assign DATA_OUT = rd_data_reg;
    assign BUSY = ~fifo_in_ready | (rd_state_reg != ST_IDLE);
    assign VRAM_RD_REQ = rd_state_reg == ST_REQ;
    assign VRAM_RD_ADDR = cursor_reg;
    assign PARAMS = params_reg;
    assign CURSOR_ADDR = cursor_reg;
    assign TIMING_RESTART = restart_reg;
    assign DRIVE_BLANK_OUT = drive_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);

    sequence s_sleep;
        new_cmd && new_kind == K_SLEEP;
    endsequence

    sequence s_vram_read_cmd;
        new_cmd && new_kind == K_MRD;
    endsequence

    index_restart_a: assert property (new_cmd |=> idx_reg == 4'h0) // [RULE19]
        else $error("parameter index not restarted by command");
    disp_flag_a: assert property (new_cmd && new_kind == K_DISP
        |=> params_reg.display_on == $past(op.data[0])) // [RULE4]
        else $error("display flag not taken from code bit 0");
    dir_cmd_a: assert property (new_cmd && new_kind == K_DIR
        |=> params_reg.cursor_dir == $past(op.data[1:0]) && idx_reg == 4'h0) // [RULE8]
        else $error("cursor direction not taken from code");
    init_byte_a: assert property (param_wr && kind == K_INIT && idx_reg == 4'h0
        |=> params_reg.init[0] == $past(op.data)) // [RULE12]
        else $error("first init byte not stored at once");
    char_pair_a: assert property (param_wr && kind == K_CGRAM && idx_reg == 4'h0
        |=> $stable(params_reg.char_base)) // [RULE14]
        else $error("lone char RAM byte committed");
    cursor_low_a: assert property (param_wr && kind == K_CURW && idx_reg == 4'h0
        |=> cursor_reg[7:0] == $past(op.data)
            && cursor_reg[15:8] == $past(cursor_reg[15:8])) // [RULE9]
        else $error("cursor low byte write disturbed high byte");
    vram_write_cmd_step_a: assert property (mwr_taken
        |=> cursor_reg == step($past(cursor_reg), params_reg.cursor_dir, pitch)) // [RULE10]
        else $error("cursor not stepped after memory write");
    vram_read_cmd_req_a: assert property (s_vram_read_cmd |=> VRAM_RD_REQ ##1 !VRAM_RD_REQ) // [RULE11]
        else $error("memory read not requested once");
    sleep_drive_a: assert property (s_sleep |=> DRIVE_BLANK_OUT [*2]) // [RULE16]
        else $error("drive dropped before a frame edge");
    blank_edge_a: assert property ($fell(DRIVE_BLANK_OUT)
        |-> $past(params_reg.standby && frame_tick && blank_cnt_reg)) // [RULE17]
        else $error("drive dropped without second frame edge");
    init_restart_a: assert property (init_cmd
        |=> TIMING_RESTART && !params_reg.display_on && !params_reg.standby) // [RULE18]
        else $error("init did not restart timing");
endmodule

// ---- tb/host_cpu_model.sv ----
/*
 * Host processor model that drives the parallel port in 8080 or 6800 style.
 * Assumes the bench calls access just after a rising clock edge.
 */
`timescale 1ns/1ps
module host_cpu_model (
    input wire logic clk,
    output logic style_a,
    output logic cs_n,
    output logic cd,
    output logic rd_e,
    output logic wr_rw,
    output logic [7:0] dq,
    input wire logic [7:0] dout
);
    logic m68 = 1'b0;
    logic act_rd = 1'b0;
    logic act_wr = 1'b0;
    // Idle bus at time zero
    initial begin
        cs_n = 1'b1;
        cd = 1'b0;
        dq = 8'h00;
    end
    // Style pin follows the bus the model speaks
    assign style_a = m68;
    // 8080: low strobes; 6800: high enable, direction idles at read
    assign rd_e = m68 ? (act_rd | act_wr) : ~act_rd;
    assign wr_rw = ~act_wr;
    ////////////////////////////////////////////////////////////////////////
    // Strobe two cycles, idle two, so the edge detector sees each access
    task automatic access(input logic rd, input logic c, input logic [7:0] d,
            output logic [7:0] q);
        cs_n <= 1'b0;
        cd <= c;
        dq <= d;
        act_rd <= rd;
        act_wr <= ~rd;
        repeat (2) @(posedge clk);
        q = dout;
        cs_n <= 1'b1;
        act_rd <= 1'b0;
        act_wr <= 1'b0;
        // Released bus shows the inverse, not a stale copy
        dq <= ~d;
        repeat (2) @(posedge clk);
    endtask
endmodule

// ---- tb/lcd_host_command_decoder_bench.sv ----
/*
 * Bench of the host command decoder: a table of short commands, then
 * hand-written cases. Assumes the host model owns the parallel port.
 */
`timescale 1ns/1ps
module lcd_host_command_decoder_bench import lcd_cmd_pkg::*;;
    typedef struct packed {logic [7:0] c; logic [7:0] p;} row_t;
    logic CLOCK = 1'b0, RESET = 1'b1, VRAM_WR_READY = 1'b0, VRAM_RD_VALID = 1'b0;
    logic [7:0] VRAM_RD_DATA = 8'h00, q, din, dout;
    logic sa, cs_n, cd, rd_e, wr_rw, busy, wr_v, rd_req, blank_out, oe;
    logic [15:0] rd_addr, cursor;
    vram_wr_t wr_head;
    params_t pr;
    int n_fail = 0, cmp_count = 0, k;
    row_t rows [9] = '{'{8'h5a, 8'h07}, '{8'h5b, 8'h03}, '{8'h5d, 8'h21}, '{8'h59, 8'h16},
        '{8'h58, 8'h14}, '{8'h4f, 8'h00}, '{8'h4e, 8'h00}, '{8'h4d, 8'h00}, '{8'h4c, 8'h00}};
    always #25 CLOCK = ~CLOCK;
    lcd_host_command_decoder #(.FRAME_CYCLES(20)) DUT (.CLOCK(CLOCK), .RESET(RESET),
        .BUS_STYLE_SELECT_A(sa), .BUS_STYLE_SELECT_B(1'b0), .CHIP_SELECT_N(cs_n),
        .COMMAND_DATA_SELECT(cd), .STROBE_RD_E(rd_e), .STROBE_WR_RW(wr_rw), .DATA_IN(din),
        .DATA_OUT(dout), .DATA_OE(oe), .BUSY(busy), .VRAM_WR(wr_head), .VRAM_WR_VALID(wr_v),
        .VRAM_WR_READY(VRAM_WR_READY), .VRAM_RD_REQ(rd_req), .VRAM_RD_ADDR(rd_addr),
        .VRAM_RD_VALID(VRAM_RD_VALID), .VRAM_RD_DATA(VRAM_RD_DATA), .PARAMS(pr),
        .CURSOR_ADDR(cursor), .TIMING_RESTART(), .DRIVE_BLANK_OUT(blank_out));
    host_cpu_model host (.clk(CLOCK), .style_a(sa), .cs_n(cs_n), .cd(cd), .rd_e(rd_e),
        .wr_rw(wr_rw), .dq(din), .dout(dout));
    // Display memory answers a fetch one cycle later with address xor 5a
    always @(posedge CLOCK) begin
        VRAM_RD_VALID <= rd_req;
        VRAM_RD_DATA <= rd_addr[7:0] ^ 8'h5a;
    end
    // Data bus may turn only while a selected read strobe stands
    always @(negedge CLOCK) check(oe, host.act_rd & ~cs_n);
    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Command then n data bytes counting up from d0
    task automatic seq(input logic [7:0] c, input int n, input logic [7:0] d0);
        host.access(1'b0, 1'b1, c, q);
        for (int i = 0; i < n; i++) host.access(1'b0, 1'b0, d0 + 8'(i), q);
    endtask
    // Fetch starts two edges after a read ends, so wait that long for BUSY
    task automatic rd(input logic [7:0] exp);
        repeat (2) @(posedge CLOCK);
        for (k = 0; k < 20 && busy !== 1'b0; k++) @(posedge CLOCK);
        if (k == 20) begin
            n_fail++;
            final_report();
        end
        host.access(1'b1, 1'b0, 8'h00, q);
        check(q, exp);
    endtask
    function automatic logic [7:0] seen(input logic [7:0] c);
        case (c)
            8'h5a: return pr.pan;
            8'h5b: return pr.overlay;
            8'h5d: return pr.shape[0];
            8'h58, 8'h59: return pr.disp_attr;
            default: return {6'h00, pr.cursor_dir};
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        check(blank_out, 1);
        check({busy, pr === '0, cursor}, {2'b01, 16'h0000});
        // Short commands, one byte each; direction codes ignore the byte
        foreach (rows[i]) begin
            seq(rows[i].c, 1, rows[i].p);
            check(seen(rows[i].c), rows[i].c[7:2] == 6'h13 ? rows[i].c[1:0] : rows[i].p);
            if (rows[i].c[7:1] == 7'h2c) check(pr.display_on, rows[i].c[0]);
        end
        // Paired bytes commit together; a lone first byte is lost
        seq(8'h5c, 2, 8'h56);
        check(pr.char_base, 16'h5756);
        seq(8'h5c, 1, 8'h99);
        seq(8'h44, 4, 8'h11);
        check({pr.scroll[2], pr.scroll[1], pr.scroll[0]}, 24'h131211);
        seq(8'h46, 2, 8'h34);
        check({pr.scroll[3], pr.char_base}, 24'h005756);
        check(cursor, 16'h3534);
        seq(8'h46, 1, 8'h56);
        check(cursor, 16'h3556);
        seq(8'h47, 0, 8'h00);
        rd(8'h56);
        rd(8'h35);
        // Stalled memory: 16 bytes fill the buffer, the 17th is refused
        seq(8'h42, 17, 8'h80);
        check({busy, cursor}, {1'b1, 16'h3566});
        VRAM_WR_READY <= 1'b1;
        k = 0;
        repeat (24) begin
            @(negedge CLOCK);
            if (wr_v === 1'b1) begin
                check(wr_head, {16'h3556 + 16'(k), 8'h80 + 8'(k)});
                k++;
            end
        end
        check(k, 16);
        @(posedge CLOCK);
        seq(8'h43, 0, 8'h00);
        rd(8'h66 ^ 8'h5a);
        rd(8'h67 ^ 8'h5a);
        // Standby blanks drive after one to two frames of 20 cycles
        seq(8'h53, 0, 8'h00);
        check(blank_out, 1);
        for (k = 0; k < 45 && blank_out !== 1'b0; k++) @(negedge CLOCK);
        check(k > 19 && k < 40, 1);
        if (k == 45) final_report();
        @(posedge CLOCK);
        seq(8'h40, 7, 8'h10);
        seq(8'h5a, 0, 8'h00);
        check({blank_out, pr.display_on, pr.init[6], pr.init[7]}, {2'b10, 16'h1600});
        // Pitch and backward steps; init bytes 7 and 6 give a pitch of 0016
        seq(8'h46, 2, 8'h20);
        seq(8'h4f, 0, 8'h00);
        seq(8'h42, 1, 8'h77);
        check(cursor, 16'h2136);
        seq(8'h4d, 0, 8'h00);
        seq(8'h42, 1, 8'h78);
        check(cursor, 16'h2135);
        // Same port in 6800 style
        host.m68 <= 1'b1;
        @(posedge CLOCK);
        seq(8'h5a, 1, 8'h3c);
        check(pr.pan, 8'h3c);
        final_report();
    end
endmodule
